// [inc/ddrpi_pkg.sv]
package ddrpi_pkg;
    // Pin widths
    localparam int ROW_W = 15;
    localparam int COL_W = 10;
    localparam int BANK_W = 3;
    localparam int NBANK = 8;
    localparam int DQ_W = 16;
    // Address bits with extra meaning
    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;
    // Mode register select on the bank pins
    localparam logic [2:0] MR0_SEL = 3'h0;
    localparam logic [2:0] MR1_SEL = 3'h1;
    localparam logic [2:0] MR2_SEL = 3'h2;
    // Mode field positions and codes
    localparam int MR0_BL_LSB = 0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam int MR1_RTT_B0 = 2;
    localparam int MR1_RTT_B1 = 6;
    localparam int MR1_RTT_B2 = 9;
    localparam int MR2_RTT_LSB = 9;
    // Reset values of stored mode fields
    localparam logic [1:0] MR0_BL_RST = 2'h0;
    localparam logic [2:0] MR1_RTT_RST = 3'h0;
    localparam logic [1:0] MR2_RTT_RST = 2'h0;
    // Write beats per burst
    localparam logic [3:0] BEATS_BL8 = 4'h8;
    localparam logic [3:0] BEATS_BC4 = 4'h4;
    // Bit positions in the one-hot power state
    localparam int PS_PPD_BIT = 1;
    localparam int PS_APD_BIT = 2;
    // Commands as {cs_n, ras_n, cas_n, we_n}
    typedef enum logic [3:0] {
        CMD_MRS = 4'h0,
        CMD_REF = 4'h1,
        CMD_PRE = 4'h2,
        CMD_ACT = 4'h3,
        CMD_WR = 4'h4,
        CMD_RD = 4'h5,
        CMD_ZQC = 4'h6,
        CMD_NOP = 4'h7,
        CMD_DES = 4'h8
    } ddrpi_cmd_t;
    // Power states
    typedef enum logic [3:0] {
        PS_ACTIVE = 4'h1,
        PS_PPD = 4'h2,
        PS_APD = 4'h4,
        PS_SREF = 4'h8
    } ddrpi_pwr_t;
    // Command from the four command pins
    function automatic ddrpi_cmd_t ddrpi_decode(input logic cs_n, input logic ras_n,
                                                input logic cas_n, input logic we_n);
        ddrpi_cmd_t c;
        c = CMD_DES;
        if (!cs_n) begin
            c = ddrpi_cmd_t'({1'b0, ras_n, cas_n, we_n});
        end
        return c;
    endfunction
    // Read or write access
    function automatic logic ddrpi_is_rw(input ddrpi_cmd_t c);
        return (c == CMD_RD) || (c == CMD_WR);
    endfunction
endpackage

// [rtl/ddrpi_bank_track.sv]
`timescale 1ns/1ps
module ddrpi_bank_track
    import ddrpi_pkg::*;
(
    // Memory clock and reset
    input wire logic mem_ck,
    input wire logic arst_n,
    // Executed command
    input wire logic exec,
    input wire ddrpi_cmd_t cmd,
    input wire logic [BANK_W-1:0] bank,
    input wire logic a10,
    // Open row flag per bank
    output logic [NBANK-1:0] bank_open
);
    typedef struct packed {
        logic [NBANK-1:0] open_r;
    } ddrpi_bk_t;

    ddrpi_bk_t bk_r, bk_nxt;

    // Row open and close bookkeeping
    always_comb begin
        bk_nxt = bk_r;
        if (exec) begin
            case (cmd)
                // Bank pins pick the bank
                CMD_ACT: begin
                    bk_nxt.open_r[bank] = 1'b1;
                end
                // One bank or all banks
                CMD_PRE: begin
                    if (a10) begin
                        bk_nxt.open_r = '0;
                    end else begin
                        bk_nxt.open_r[bank] = 1'b0;
                    end
                end
                // Auto-precharge closes the row
                CMD_RD, CMD_WR: begin
                    if (a10) begin
                        bk_nxt.open_r[bank] = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge mem_ck or negedge arst_n) begin
        if (!arst_n) begin
            bk_r <= '0;
        end else begin
            bk_r <= bk_nxt;
        end
    end

    assign bank_open = bk_r.open_r;

    act_opens_a: assert property (@(posedge mem_ck) disable iff (!arst_n)
        exec && cmd == CMD_ACT |=> bank_open[$past(bank)])
        else $error("activate did not open bank");
    pre_all_a: assert property (@(posedge mem_ck) disable iff (!arst_n)
        exec && cmd == CMD_PRE && a10 |=> bank_open == '0)
        else $error("precharge all left a bank open");
    auto_pre_a: assert property (@(posedge mem_ck) disable iff (!arst_n)
        exec && ddrpi_is_rw(cmd) && a10 |=> !bank_open[$past(bank)])
        else $error("auto-precharge left row open");
endmodule // ddrpi_bank_track

// [rtl/ddrpi_cmd_pins.sv]
`timescale 1ns/1ps
module ddrpi_cmd_pins
    import ddrpi_pkg::*;
(
    // Core clock and reset pin
    input wire logic ref_clk,
    input wire logic arst_n,
    // Memory clock crossing
    input wire logic mem_ck,
    // Command and address pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [BANK_W-1:0] ba,
    input wire logic [ROW_W-1:0] addr,
    input wire logic odt,
    // Write data lanes
    input wire logic [DQ_W-1:0] dq,
    input wire logic lower_byte_strobe,
    input wire logic upper_byte_strobe,
    input wire logic lower_byte_write_mask,
    input wire logic upper_byte_write_mask,
    // Decoded command
    output logic cmd_valid,
    output ddrpi_cmd_t cmd_code,
    output logic [BANK_W-1:0] cmd_bank,
    output logic [ROW_W-1:0] cmd_row,
    output logic [COL_W-1:0] cmd_col,
    output logic cmd_auto_pre,
    output logic cmd_pre_all,
    output logic cmd_chop,
    // Power controls
    output logic int_clk_en,
    output logic out_drv_en,
    output logic in_buf_en,
    output logic ctl_buf_en,
    output logic pd_active,
    output logic pd_precharge,
    output logic self_refresh,
    // Termination enables
    output logic term_dq_en,
    output logic [1:0] term_strobe_en,
    output logic [1:0] term_mask_en,
    // Write beats
    output logic [1:0] wr_beat,
    output logic [1:0] wr_byte_en,
    output logic [DQ_W-1:0] wr_data
);
    // Memory clock side state
    typedef struct packed {
        logic cke_r;
        logic cke_prev_r;
        logic cs_n_r;
        logic ras_n_r;
        logic cas_n_r;
        logic we_n_r;
        logic [BANK_W-1:0] ba_r;
        logic [ROW_W-1:0] addr_r;
        logic odt_r;
        logic term_r;
        ddrpi_pwr_t pst_r;
        logic [1:0] mr0_bl_r;
        logic [2:0] mr1_rtt_r;
        logic [1:0] mr2_rtt_r;
        ddrpi_cmd_t h_code_r;
        logic [BANK_W-1:0] h_bank_r;
        logic [ROW_W-1:0] h_addr_r;
        logic h_chop_r;
        logic h_apre_r;
        logic h_pall_r;
        logic tgl_r;
        logic sr_tgl_r;
    } ddrpi_lk_t;

    // Core clock side state
    typedef struct packed {
        logic tgl_d_r;
        logic srt_d_r;
        logic sr_r;
        logic [1:0] stb_d_r;
        logic cmd_valid_r;
        ddrpi_cmd_t cmd_code_r;
        logic [BANK_W-1:0] cmd_bank_r;
        logic [ROW_W-1:0] cmd_row_r;
        logic [COL_W-1:0] cmd_col_r;
        logic cmd_chop_r;
        logic cmd_apre_r;
        logic cmd_pall_r;
        logic clk_en_r;
        logic drv_en_r;
        logic buf_en_r;
        logic ctl_en_r;
        logic term_r;
        logic apd_r;
        logic ppd_r;
        logic [1:0][3:0] cnt_r;
        logic [1:0] beat_r;
        logic [1:0] byte_en_r;
        logic [DQ_W-1:0] wdata_r;
    } ddrpi_rf_t;

    ddrpi_lk_t lk_r, lk_nxt;
    ddrpi_rf_t rf_r, rf_nxt;
    ddrpi_cmd_t lk_cmd; // Command in the capture stage
    logic lk_exec; // Command is carried out
    logic rtt_en; // Any termination value programmed
    logic [NBANK-1:0] bank_open; // Rows open per bank
    logic [5:0] lk_s; // {cke, term, apd, ppd, sr toggle, cmd toggle}
    logic [DQ_W+3:0] dt_s; // {dq, masks, strobes}

    // Command code from the captured pins
    assign lk_cmd = ddrpi_decode(lk_r.cs_n_r, lk_r.ras_n_r, lk_r.cas_n_r, lk_r.we_n_r);
    // Only with the enable held high across two edges
    assign lk_exec = lk_r.cke_r && lk_r.cke_prev_r && lk_r.pst_r == PS_ACTIVE
        && lk_cmd != CMD_DES && lk_cmd != CMD_NOP;
    assign rtt_en = (|lk_r.mr1_rtt_r) || (|lk_r.mr2_rtt_r);

    // Link side: capture, power state, mode fields, hand-off word
    always_comb begin
        lk_nxt = lk_r;
        lk_nxt.cke_r = cke;
        lk_nxt.cke_prev_r = lk_r.cke_r;
        // Command buffers live only while active
        if (lk_r.pst_r == PS_ACTIVE) begin
            lk_nxt.cs_n_r = cs_n;
            lk_nxt.ras_n_r = ras_n;
            lk_nxt.cas_n_r = cas_n;
            lk_nxt.we_n_r = we_n;
            lk_nxt.ba_r = ba;
            lk_nxt.addr_r = addr;
        end else begin
            lk_nxt.cs_n_r = 1'b1;
        end
        // Termination input dead in self-refresh
        lk_nxt.odt_r = (lk_r.pst_r != PS_SREF) && odt;
        lk_nxt.term_r = lk_r.odt_r && rtt_en && lk_r.pst_r != PS_SREF;
        // Power state machine
        case (lk_r.pst_r)
            PS_ACTIVE: begin
                if (lk_r.cke_prev_r && !lk_r.cke_r) begin
                    if (lk_cmd == CMD_REF) begin
                        lk_nxt.pst_r = PS_SREF;
                        lk_nxt.sr_tgl_r = !lk_r.sr_tgl_r;
                    end else if (|bank_open) begin
                        lk_nxt.pst_r = PS_APD;
                    end else begin
                        lk_nxt.pst_r = PS_PPD;
                    end
                end
            end
            // Enable back high wakes the device
            PS_PPD, PS_APD, PS_SREF: begin
                if (lk_r.cke_r) begin
                    lk_nxt.pst_r = PS_ACTIVE;
                end
            end
            default: begin
                lk_nxt.pst_r = PS_ACTIVE;
            end
        endcase
        // Executed command: hold word and flip toggle
        if (lk_exec) begin
            lk_nxt.h_code_r = lk_cmd;
            lk_nxt.h_bank_r = lk_r.ba_r;
            lk_nxt.h_addr_r = lk_r.addr_r;
            lk_nxt.h_apre_r = ddrpi_is_rw(lk_cmd) && lk_r.addr_r[AP_BIT];
            lk_nxt.h_pall_r = (lk_cmd == CMD_PRE) && lk_r.addr_r[AP_BIT];
            lk_nxt.h_chop_r = ddrpi_is_rw(lk_cmd) && lk_r.mr0_bl_r == BL_OTF
                && !lk_r.addr_r[BC_BIT];
            lk_nxt.tgl_r = !lk_r.tgl_r;
        end
        // Mode set: bank picks register, address is opcode
        if (lk_exec && lk_cmd == CMD_MRS) begin
            case (lk_r.ba_r)
                MR0_SEL: begin
                    lk_nxt.mr0_bl_r = lk_r.addr_r[MR0_BL_LSB +: 2];
                end
                MR1_SEL: begin
                    lk_nxt.mr1_rtt_r = {lk_r.addr_r[MR1_RTT_B2], lk_r.addr_r[MR1_RTT_B1],
                        lk_r.addr_r[MR1_RTT_B0]};
                end
                MR2_SEL: begin
                    lk_nxt.mr2_rtt_r = lk_r.addr_r[MR2_RTT_LSB +: 2];
                end
                default: begin
                end
            endcase
        end
    end

    // Link register; reset wipes mode and bank state
    always_ff @(posedge mem_ck or negedge arst_n) begin
        if (!arst_n) begin
            lk_r <= '0;
            lk_r.cs_n_r <= 1'b1;
            lk_r.pst_r <= PS_ACTIVE;
            lk_r.h_code_r <= CMD_NOP;
            lk_r.mr0_bl_r <= MR0_BL_RST;
            lk_r.mr1_rtt_r <= MR1_RTT_RST;
            lk_r.mr2_rtt_r <= MR2_RTT_RST;
        end else begin
            lk_r <= lk_nxt;
        end
    end

    // Open rows per bank
    ddrpi_bank_track u_bank (
        .mem_ck(mem_ck),
        .arst_n(arst_n),
        .exec(lk_exec),
        .cmd(lk_cmd),
        .bank(lk_r.ba_r),
        .a10(lk_r.addr_r[AP_BIT]),
        .bank_open(bank_open)
    );

    // Link levels and toggles into the core domain; raw enable pin too
    ddrpi_sync2 #(.W(6)) u_lk_sync (
        .clk(ref_clk),
        .rst_n(arst_n),
        .d({cke, lk_r.term_r, lk_r.pst_r[PS_APD_BIT], lk_r.pst_r[PS_PPD_BIT], lk_r.sr_tgl_r, lk_r.tgl_r}),
        .q(lk_s)
    );

    // Write lanes into the core domain
    ddrpi_sync2 #(.W(DQ_W + 4)) u_dt_sync (
        .clk(ref_clk),
        .rst_n(arst_n),
        .d({dq, upper_byte_write_mask, lower_byte_write_mask, upper_byte_strobe, lower_byte_strobe}),
        .q(dt_s)
    );

    // Core side: command delivery, power outputs, write masking
    always_comb begin
        rf_nxt = rf_r;
        rf_nxt.tgl_d_r = lk_s[0];
        rf_nxt.srt_d_r = lk_s[1];
        rf_nxt.stb_d_r = dt_s[1:0];
        rf_nxt.cmd_valid_r = 1'b0;
        rf_nxt.beat_r = 2'h0;
        // Self-refresh exit straight from the enable pin
        if (lk_s[1] != rf_r.srt_d_r) begin
            rf_nxt.sr_r = 1'b1;
        end else if (lk_s[5]) begin
            rf_nxt.sr_r = 1'b0;
        end
        // Enable pin gates clocks, drivers and input buffers
        rf_nxt.clk_en_r = lk_s[5];
        rf_nxt.drv_en_r = lk_s[5];
        rf_nxt.buf_en_r = lk_s[5] && !rf_r.sr_r;
        rf_nxt.ctl_en_r = !rf_r.sr_r;
        rf_nxt.term_r = lk_s[4] && !rf_r.sr_r;
        rf_nxt.apd_r = lk_s[3];
        rf_nxt.ppd_r = lk_s[2];
        // Each lane takes a beat on either strobe edge
        // Write strobe edges are taken as centred in the data eye
        for (int i = 0; i < 2; i++) begin
            if (dt_s[i] != rf_r.stb_d_r[i] && rf_r.cnt_r[i] != 4'h0) begin
                rf_nxt.beat_r[i] = 1'b1;
                rf_nxt.byte_en_r[i] = !dt_s[2 + i];
                rf_nxt.wdata_r[8 * i +: 8] = dt_s[4 + 8 * i +: 8];
                rf_nxt.cnt_r[i] = rf_r.cnt_r[i] - 4'h1;
            end
        end
        // New command word; held fields are stable once the toggle lands
        if (lk_s[0] != rf_r.tgl_d_r) begin
            rf_nxt.cmd_valid_r = 1'b1;
            rf_nxt.cmd_code_r = lk_r.h_code_r;
            rf_nxt.cmd_bank_r = lk_r.h_bank_r;
            rf_nxt.cmd_row_r = lk_r.h_addr_r;
            rf_nxt.cmd_col_r = lk_r.h_addr_r[COL_W-1:0];
            rf_nxt.cmd_chop_r = lk_r.h_chop_r;
            rf_nxt.cmd_apre_r = lk_r.h_apre_r;
            rf_nxt.cmd_pall_r = lk_r.h_pall_r;
            // Arm both lanes for the burst length
            if (lk_r.h_code_r == CMD_WR) begin
                rf_nxt.cnt_r[0] = lk_r.h_chop_r ? BEATS_BC4 : BEATS_BL8;
                rf_nxt.cnt_r[1] = lk_r.h_chop_r ? BEATS_BC4 : BEATS_BL8;
            end
        end
    end

    // Core register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rf_r <= '0;
            rf_r.cmd_code_r <= CMD_NOP;
        end else begin
            rf_r <= rf_nxt;
        end
    end

    // Outputs straight from flops
    assign cmd_valid = rf_r.cmd_valid_r;
    assign cmd_code = rf_r.cmd_code_r;
    assign cmd_bank = rf_r.cmd_bank_r;
    assign cmd_row = rf_r.cmd_row_r;
    assign cmd_col = rf_r.cmd_col_r;
    assign cmd_auto_pre = rf_r.cmd_apre_r;
    assign cmd_pre_all = rf_r.cmd_pall_r;
    assign cmd_chop = rf_r.cmd_chop_r;
    assign int_clk_en = rf_r.clk_en_r;
    assign out_drv_en = rf_r.drv_en_r;
    assign in_buf_en = rf_r.buf_en_r;
    assign ctl_buf_en = rf_r.ctl_en_r;
    assign pd_active = rf_r.apd_r;
    assign pd_precharge = rf_r.ppd_r;
    assign self_refresh = rf_r.sr_r;
    assign term_dq_en = rf_r.term_r;
    assign term_strobe_en = {rf_r.term_r, rf_r.term_r};
    assign term_mask_en = {rf_r.term_r, rf_r.term_r};
    assign wr_beat = rf_r.beat_r;
    assign wr_byte_en = rf_r.byte_en_r;
    assign wr_data = rf_r.wdata_r;

    // Steps of a self-refresh entry
    sequence sr_entry_s;
        lk_r.pst_r == PS_ACTIVE && lk_r.cke_prev_r && !lk_r.cke_r && lk_cmd == CMD_REF;
    endsequence
    sequence in_sref_s;
        lk_r.pst_r == PS_SREF;
    endsequence

    sr_enter_a: assert property (@(posedge mem_ck) disable iff (!arst_n)
        sr_entry_s |=> in_sref_s ##0 (lk_r.sr_tgl_r != $past(lk_r.sr_tgl_r)))
        else $error("self-refresh entry missed");
    sr_odt_a: assert property (@(posedge mem_ck) disable iff (!arst_n)
        lk_r.pst_r == PS_SREF |=> !lk_r.odt_r && lk_r.cs_n_r)
        else $error("termination request live in self-refresh");
    apd_enter_a: assert property (@(posedge mem_ck) disable iff (!arst_n)
        lk_r.pst_r == PS_ACTIVE && lk_r.cke_prev_r && !lk_r.cke_r && lk_cmd != CMD_REF
        |-> ##1 lk_r.pst_r == (($past(bank_open) != '0) ? PS_APD : PS_PPD))
        else $error("wrong power-down kind");
    cs_mask_a: assert property (@(posedge mem_ck) disable iff (!arst_n)
        lk_r.cs_n_r |=> $stable(lk_r.tgl_r))
        else $error("deselected command executed");
    pd_inputs_a: assert property (@(posedge mem_ck) disable iff (!arst_n)
        lk_r.pst_r != PS_ACTIVE |=> lk_r.cs_n_r)
        else $error("command buffers live in power-down");
    chop_sel_a: assert property (@(posedge mem_ck) disable iff (!arst_n)
        lk_exec && ddrpi_is_rw(lk_cmd) |=> lk_r.h_chop_r ==
        (($past(lk_r.mr0_bl_r) == BL_OTF) && !$past(lk_r.addr_r[BC_BIT])))
        else $error("burst chop chosen wrongly");
    cmd_deliver_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        lk_s[0] != rf_r.tgl_d_r |=> cmd_valid ##1 !cmd_valid)
        else $error("command not delivered once");
    sr_exit_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        rf_r.sr_r && lk_s[5] && lk_s[1] == rf_r.srt_d_r |=> !self_refresh ##1 in_buf_en)
        else $error("self-refresh exit not seen");
    term_sref_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        rf_r.sr_r |=> !term_dq_en && term_mask_en == 2'h0 && !in_buf_en)
        else $error("termination live in self-refresh");
    cke_low_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !lk_s[5] [*2] |-> !int_clk_en && !out_drv_en && !in_buf_en)
        else $error("clocks running with enable low");
    mask_lane_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_beat[0] |-> wr_byte_en[0] == !$past(dt_s[2]))
        else $error("write mask not applied");
endmodule // ddrpi_cmd_pins

// [rtl/ddrpi_sync2.sv]
`timescale 1ns/1ps
module ddrpi_sync2 #(parameter int W = 1) (
    // Destination clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Levels from another domain
    input wire logic [W-1:0] d,
    // Synchronised levels
    output logic [W-1:0] q
);
    // Two flops per bit
    typedef struct packed {
        logic [W-1:0] meta_r;
        logic [W-1:0] sync_r;
    } ddrpi_sync_t;

    ddrpi_sync_t st_r, st_nxt;

    // Meta stage feeds only the second stage
    always_comb begin
        st_nxt.meta_r = d;
        st_nxt.sync_r = st_r.meta_r;
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.sync_r;
endmodule // ddrpi_sync2

// [tb/ddrpi_cmd_pins_bench.sv]
`timescale 1ns/1ps
module ddrpi_cmd_pins_bench
    import ddrpi_pkg::*;
;
    logic ref_clk, mem_ck, arst_n, cke, cs_n, ras_n, cas_n, we_n, odt;
    logic [2:0] ba;
    logic [14:0] addr;
    logic [15:0] dq, wr_data;
    logic [1:0] strobe, wmask, wr_beat, wr_byte_en;
    logic cmd_valid, cmd_auto_pre, cmd_pre_all, cmd_chop, in_buf_en, pd_precharge, self_refresh, term_dq_en;
    logic int_clk_en, out_drv_en, ctl_buf_en, pd_active;
    logic [1:0] term_strobe_en, term_mask_en;
    ddrpi_cmd_t cmd_code;
    logic [2:0] cmd_bank;
    logic [14:0] cmd_row;
    logic [9:0] cmd_col;
    int fails = 0;
    int num_checks = 0;

    // Clocks unrelated in phase
    initial begin
        ref_clk = 0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        mem_ck = 0;
        #7;
        forever #32 mem_ck = ~mem_ck;
    end

    ddrpi_ctrl_model i_ctl (.mem_ck(mem_ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .ba(ba), .addr(addr), .odt(odt), .dq(dq), .strobe(strobe), .wmask(wmask));

    ddrpi_cmd_pins i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .mem_ck(mem_ck), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt), .dq(dq),
        .lower_byte_strobe(strobe[0]), .upper_byte_strobe(strobe[1]),
        .lower_byte_write_mask(wmask[0]), .upper_byte_write_mask(wmask[1]),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank), .cmd_row(cmd_row),
        .cmd_col(cmd_col), .cmd_auto_pre(cmd_auto_pre), .cmd_pre_all(cmd_pre_all), .cmd_chop(cmd_chop),
        .int_clk_en(int_clk_en), .out_drv_en(out_drv_en), .in_buf_en(in_buf_en), .ctl_buf_en(ctl_buf_en),
        .pd_active(pd_active), .pd_precharge(pd_precharge), .self_refresh(self_refresh),
        .term_dq_en(term_dq_en), .term_strobe_en(term_strobe_en), .term_mask_en(term_mask_en),
        .wr_beat(wr_beat), .wr_byte_en(wr_byte_en), .wr_data(wr_data));

    // Compare and count
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask

    // Verdict and end of run
    task wrap_up;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Bounded wait for the command pulse, or its absence
    task wait_cmd(input logic e);
        logic got;
        got = 0;
        for (int i = 0; i < 40 && !got; i++) begin
            @(posedge ref_clk);
            #1;
            got = (cmd_valid === 1'b1);
        end
        chk("cmd_valid", 16'(got), 16'(e));
        if (e && !got) wrap_up();
    endtask

    // Levels settle within a few core cycles of a memory edge
    task settle;
        repeat (2) @(posedge mem_ck);
        repeat (6) @(posedge ref_clk);
        #1;
    endtask

    // Bounded wait for a beat on one lane
    task lane_beat(input int l, input logic e, input logic [7:0] d);
        logic got;
        got = 0;
        for (int i = 0; i < 40 && !got; i++) begin
            @(posedge ref_clk);
            #1;
            got = (wr_beat[l] === 1'b1);
        end
        chk("beat", 16'(got), 16'h0001);
        chk("byte_en", 16'(wr_byte_en[l]), 16'(e));
        if (e) chk("wr_data", 16'(wr_data[8*l +: 8]), 16'(d));
    endtask

    // Mode register writes and termination
    task t_mode;
        i_ctl.lvl(1, 1);
        settle();
        chk("term_off", 16'(term_dq_en), 16'h0000);
        i_ctl.lvl(1, 0);
        i_ctl.issue(CMD_MRS, MR0_SEL, 15'h0001, 1);
        wait_cmd(1);
        chk("mrs_code", 16'(cmd_code), 16'(CMD_MRS));
        chk("mrs_row", 16'(cmd_row), 16'h0001);
        i_ctl.issue(CMD_MRS, MR1_SEL, 15'h0004, 1);
        wait_cmd(1);
        chk("mrs_bank", 16'(cmd_bank), 16'(MR1_SEL));
        i_ctl.lvl(1, 1);
        settle();
        chk("term_on", 16'(term_dq_en), 16'h0001);
        chk("term_stb", 16'(term_strobe_en), 16'h0003);
        chk("term_mask", 16'(term_mask_en), 16'h0003);
        $display("mode done");
    endtask

    // Activate, chopped auto-precharge write with one masked beat
    task t_access;
        i_ctl.issue(CMD_ACT, 3'h2, 15'h7FFF, 1);
        wait_cmd(1);
        chk("act_row", 16'(cmd_row), 16'h7FFF);
        chk("act_bank", 16'(cmd_bank), 16'h0002);
        chk("act_code", 16'(cmd_code), 16'(CMD_ACT));
        i_ctl.issue(CMD_WR, 3'h2, 15'h07FF, 1);
        wait_cmd(1);
        chk("wr_col", 16'(cmd_col), 16'h03FF);
        chk("auto_pre", 16'(cmd_auto_pre), 16'h0001);
        chk("chop", 16'(cmd_chop), 16'h0001);
        i_ctl.beat(0, 16'h00A5, 1);
        lane_beat(0, 0, 8'hA5);
        i_ctl.beat(0, 16'h005A, 0);
        lane_beat(0, 1, 8'h5A);
        i_ctl.beat(1, 16'h3C00, 0);
        lane_beat(1, 1, 8'h3C);
        $display("access done");
    endtask

    // Deselect and precharge forms
    task t_select;
        i_ctl.issue(4'hB, 3'h1, 15'h0123, 1);
        wait_cmd(0);
        i_ctl.issue(CMD_PRE, 3'h3, 15'h0000, 1);
        wait_cmd(1);
        chk("pre_one", 16'({cmd_pre_all, cmd_bank}), 16'h0003);
        i_ctl.issue(CMD_PRE, 3'h1, 15'h0400, 1);
        wait_cmd(1);
        chk("pre_all", 16'(cmd_pre_all), 16'h0001);
        $display("select done");
    endtask

    // Power-down, then self-refresh entry and exit
    task t_power;
        i_ctl.issue(CMD_NOP, 3'h0, 15'h0000, 0);
        settle();
        chk("pd_pre", 16'(pd_precharge), 16'h0001);
        chk("pd_clk", 16'({int_clk_en, out_drv_en, in_buf_en}), 16'h0000);
        chk("pd_ctl", 16'(ctl_buf_en), 16'h0001);
        i_ctl.lvl(1, 1);
        repeat (3) @(posedge mem_ck);
        i_ctl.issue(CMD_ACT, 3'h1, 15'h0010, 1);
        wait_cmd(1);
        i_ctl.issue(CMD_NOP, 3'h0, 15'h0000, 0);
        settle();
        chk("pd_act", 16'(pd_active), 16'h0001);
        i_ctl.lvl(1, 1);
        repeat (3) @(posedge mem_ck);
        i_ctl.issue(CMD_PRE, 3'h0, 15'h0400, 1);
        wait_cmd(1);
        i_ctl.issue(CMD_REF, 3'h0, 15'h0000, 0);
        settle();
        chk("sref", 16'(self_refresh), 16'h0001);
        chk("in_buf", 16'(in_buf_en), 16'h0000);
        chk("ctl_sref", 16'(ctl_buf_en), 16'h0000);
        chk("term_sref", 16'(term_dq_en), 16'h0000);
        i_ctl.lvl(1, 1);
        settle();
        chk("sref_exit", 16'(self_refresh), 16'h0000);
        $display("power done");
    endtask

    // Reset, scenarios, verdict
    initial begin
        arst_n = 0;
        repeat (8) @(posedge ref_clk);
        repeat (2) @(posedge mem_ck);
        chk("rst_valid", 16'(cmd_valid), 16'h0000);
        chk("rst_code", 16'(cmd_code), 16'(CMD_NOP));
        @(posedge ref_clk);
        arst_n <= 1;
        i_ctl.lvl(1, 0);
        repeat (3) @(posedge mem_ck);
        t_mode();
        t_access();
        t_select();
        t_power();
        wrap_up();
    end

    // Hang guard
    initial begin
        #400000;
        fails++;
        wrap_up();
    end
endmodule // ddrpi_cmd_pins_bench

// [tb/ddrpi_ctrl_model.sv]
`timescale 1ns/1ps
// Memory controller model driving the device pins
module ddrpi_ctrl_model
    import ddrpi_pkg::*;
(
    // Memory clock
    input wire logic mem_ck,
    // Command and address pins
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [BANK_W-1:0] ba,
    output logic [ROW_W-1:0] addr,
    output logic odt,
    // Write lanes, bit 0 lower, bit 1 upper
    output logic [DQ_W-1:0] dq,
    output logic [1:0] strobe,
    output logic [1:0] wmask
);
    // Idle pins at time zero, clock enable low through reset
    initial begin
        {cke, odt, strobe, wmask} = '0;
        {cs_n, ras_n, cas_n, we_n} = 4'hF;
        ba = '0;
        addr = '0;
        dq = '0;
    end

    // One command for one edge, then deselect with inverted lines
    task issue(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a, input logic k);
        @(posedge mem_ck);
        {cs_n, ras_n, cas_n, we_n} <= c;
        ba <= b;
        addr <= a;
        cke <= k;
        @(posedge mem_ck);
        {cs_n, ras_n, cas_n, we_n} <= 4'hF;
        ba <= ~b;
        addr <= ~a;
    endtask

    // Clock enable and termination request levels
    task lvl(input logic k, input logic o);
        @(posedge mem_ck);
        cke <= k;
        odt <= o;
    endtask

    // One strobe edge with its data and mask, held a whole memory cycle
    task beat(input int l, input logic [15:0] d, input logic m);
        @(posedge mem_ck);
        dq <= d;
        wmask[l] <= m;
        strobe[l] <= ~strobe[l];
    endtask
endmodule // ddrpi_ctrl_model
